// [src/cddt_top.v]
// register bank for sample clock detector and dc test mode, apb slave
//
// What this block does
// - software bit enables clock detector, resets off
// - status bit 2 shows sample clock running
// - status bit 1 shows clock is differential
// - option powers down channels on single-ended clock
// - bit 3 option powers down channels on loss
// - test bit 0 stops top digital clock
// - test mode drives whole i channel constant
// - separate register supplies i high byte
// - q channel constant from own two registers
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "cddt_consts.vh"
module cddt_top (
  input  wire                    pclk,                        // apb clock, 100 MHz
  input  wire                    presetn,                     // async reset, active low
  input  wire                    psel,                        // apb select
  input  wire                    penable,                     // apb enable
  input  wire                    pwrite,                      // apb direction, 1 = write
  input  wire [`CDDT_ADDR_W-1:0] paddr,                       // apb byte address
  input  wire [31:0]             pwdata,                      // apb write data
  output wire                    pready,                      // apb ready
  output reg  [31:0]             prdata,                      // apb read data
  output wire                    pslverr,                     // apb error on unmapped address
  input  wire                    sample_clock_running_raw,    // analog detector: clock present
  input  wire                    sample_clock_balanced_raw,   // analog detector: clock differential
  input  wire [15:0]             i_data_in,                   // normal i channel data
  input  wire [15:0]             q_data_in,                   // normal q channel data
  output wire [15:0]             i_data_out,                  // i channel to converter
  output wire [15:0]             q_data_out,                  // q channel to converter
  output reg                     converter_power_down,        // forced channel power-down
  output wire                    detector_enable,             // detector circuit on
  output wire                    top_logic_clock_off,         // stop top digital clock
  output wire                    constant_output_test_enable, // dc test mode active
  output wire [15:0]             i_constant_value,            // i test constant
  output wire [15:0]             q_constant_value             // q test constant
);

  reg        det_en_reg;
  reg        running_reg;
  reg        balanced_reg;
  reg        pd_loss_reg;
  reg        pd_se_reg;
  reg        clk_off_reg;
  reg        test_en_reg;
  reg  [5:0] dig_rsv_reg;
  reg  [7:0] dc_i_lo_reg;
  reg  [7:0] dc_i_hi_reg;
  reg  [7:0] dc_q_lo_reg;
  reg  [7:0] dc_q_hi_reg;
  reg  [7:0] rd_byte;
  reg        rd_hit;
  reg        pd_next;
  wire [1:0] det_sync;
  wire       wr_strobe;
  wire       running_sync;
  wire       balanced_sync;
  wire       sel_clk_det;
  wire       sel_dig_test;
  wire       sel_i_lo;
  wire       sel_i_hi;
  wire       sel_q_lo;
  wire       sel_q_hi;
  wire       wr_clk_det;
  wire       wr_dig_test;
  wire       wr_i_lo;
  wire       wr_i_hi;
  wire       wr_q_lo;
  wire       wr_q_hi;
  wire       loss_fault;
  wire       se_fault;
  reg  [7:0] clk_det_word;
  wire [7:0] dig_test_word;

  // true when the word address names the given register index
  function addr_is;
    input [`CDDT_ADDR_W-1:0] addr;
    input [`CDDT_IDX_W-1:0]  idx;
    begin
      addr_is = (addr[1:0] == 2'h0) && (addr[`CDDT_ADDR_W-1:2] == idx);
    end
  endfunction

  // detector levels come from the analog side and are not timed to pclk
  cddt_sync2 u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({sample_clock_balanced_raw, sample_clock_running_raw}),
    .sync_out (det_sync)
  );

  assign running_sync  = det_sync[0];
  assign balanced_sync = det_sync[1];

  // zero wait states keep the master simple; read data is latched in setup
  assign pready    = 1'b1;
  assign wr_strobe = psel & penable & pwrite;
  assign pslverr   = psel & penable & ~rd_hit;

  // one decode per register, shared by the write enables and the read mux
  assign sel_clk_det  = addr_is(paddr, `CDDT_IDX_CLK_DET);
  assign sel_dig_test = addr_is(paddr, `CDDT_IDX_DIG_TEST);
  assign sel_i_lo     = addr_is(paddr, `CDDT_IDX_DC_I_LO);
  assign sel_i_hi     = addr_is(paddr, `CDDT_IDX_DC_I_HI);
  assign sel_q_lo     = addr_is(paddr, `CDDT_IDX_DC_Q_LO);
  assign sel_q_hi     = addr_is(paddr, `CDDT_IDX_DC_Q_HI);

  assign wr_clk_det   = wr_strobe & sel_clk_det;
  assign wr_dig_test  = wr_strobe & sel_dig_test;
  assign wr_i_lo      = wr_strobe & sel_i_lo;
  assign wr_i_hi      = wr_strobe & sel_i_hi;
  assign wr_q_lo      = wr_strobe & sel_q_lo;
  assign wr_q_hi      = wr_strobe & sel_q_hi;

  // software-written registers, one process each so a write only touches its target
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_en_reg <= `CDDT_RST_DET_EN;
    end else if (wr_clk_det) begin
      det_en_reg <= pwdata[`CDDT_BIT_DET_EN];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_loss_reg <= `CDDT_RST_PD_LOSS;
    end else if (wr_clk_det) begin
      pd_loss_reg <= pwdata[`CDDT_BIT_PD_LOSS];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_se_reg <= `CDDT_RST_PD_SE;
    end else if (wr_clk_det) begin
      pd_se_reg <= pwdata[`CDDT_BIT_PD_SE];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_off_reg <= `CDDT_RST_CLK_OFF;
    end else if (wr_dig_test) begin
      clk_off_reg <= pwdata[`CDDT_BIT_CLK_OFF];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_en_reg <= `CDDT_RST_TEST_EN;
    end else if (wr_dig_test) begin
      test_en_reg <= pwdata[`CDDT_BIT_TEST_EN];
    end
  end

  // reserved field stays writable so read-modify-write by software round-trips
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_rsv_reg <= `CDDT_RST_DIG_RSV;
    end else if (wr_dig_test) begin
      dig_rsv_reg <= pwdata[`CDDT_RSV_MSB:`CDDT_RSV_LSB];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_i_lo_reg <= `CDDT_RST_DC_BYTE;
    end else if (wr_i_lo) begin
      dc_i_lo_reg <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_i_hi_reg <= `CDDT_RST_DC_BYTE;
    end else if (wr_i_hi) begin
      dc_i_hi_reg <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_q_lo_reg <= `CDDT_RST_DC_BYTE;
    end else if (wr_q_lo) begin
      dc_q_lo_reg <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_q_hi_reg <= `CDDT_RST_DC_BYTE;
    end else if (wr_q_hi) begin
      dc_q_hi_reg <= pwdata[7:0];
    end
  end

  // status tracks the detector only while it is enabled, else holds
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_reg <= `CDDT_RST_STATUS;
    end else if (det_en_reg) begin
      running_reg <= running_sync;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      balanced_reg <= `CDDT_RST_STATUS;
    end else if (det_en_reg) begin
      balanced_reg <= balanced_sync;
    end
  end

  // a stopped clock cannot be judged for balance, so single-ended only counts while running
  assign loss_fault = pd_loss_reg & ~running_reg;
  assign se_fault   = pd_se_reg & running_reg & ~balanced_reg;

  always @* begin
    pd_next = 1'b0;
    if (det_en_reg) begin
      if (loss_fault) begin
        pd_next = 1'b1;
      end else if (se_fault) begin
        pd_next = 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_power_down <= 1'b0;
    end else begin
      converter_power_down <= pd_next;
    end
  end

  // assembled register words; unused bits of the detector word read zero
  always @* begin
    clk_det_word                      = 8'h00;
    clk_det_word[`CDDT_BIT_DET_EN]    = det_en_reg;
    clk_det_word[`CDDT_BIT_BALANCED]  = balanced_reg;
    clk_det_word[`CDDT_BIT_RUNNING]   = running_reg;
    clk_det_word[`CDDT_BIT_PD_LOSS]   = pd_loss_reg;
    clk_det_word[`CDDT_BIT_PD_SE]     = pd_se_reg;
  end

  assign dig_test_word = {dig_rsv_reg, test_en_reg, clk_off_reg};

  // read decode
  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (sel_clk_det) begin
      rd_byte = clk_det_word;
    end else if (sel_dig_test) begin
      rd_byte = dig_test_word;
    end else if (sel_i_lo) begin
      rd_byte = dc_i_lo_reg;
    end else if (sel_i_hi) begin
      rd_byte = dc_i_hi_reg;
    end else if (sel_q_lo) begin
      rd_byte = dc_q_lo_reg;
    end else if (sel_q_hi) begin
      rd_byte = dc_q_hi_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // captured in setup so read data already stands when the access edge samples it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

  // register levels go straight out, no extra stage
  assign detector_enable             = det_en_reg;
  assign top_logic_clock_off         = clk_off_reg;
  assign constant_output_test_enable = test_en_reg;
  assign i_constant_value            = {dc_i_hi_reg, dc_i_lo_reg};
  assign q_constant_value            = {dc_q_hi_reg, dc_q_lo_reg};

  // outputs are registered so entering test mode switches on a clean edge
  cddt_test_source u_src (
    .pclk    (pclk),
    .presetn (presetn),
    .test_en (test_en_reg),
    .i_const (i_constant_value),
    .q_const (q_constant_value),
    .i_in    (i_data_in),
    .q_in    (q_data_in),
    .i_out   (i_data_out),
    .q_out   (q_data_out)
  );

endmodule

// [src/cddt_consts.vh]
// constants for the clock detector and dc test register bank
`ifndef CDDT_CONSTS_VH
`define CDDT_CONSTS_VH

`define CDDT_ADDR_W          12
`define CDDT_IDX_W           10
// register indices; byte address is four times the index
`define CDDT_IDX_CLK_DET     10'h08E
`define CDDT_IDX_DIG_TEST    10'h0F7
`define CDDT_IDX_DC_I_LO     10'h0F8
`define CDDT_IDX_DC_I_HI     10'h0F9
`define CDDT_IDX_DC_Q_LO     10'h0FA
`define CDDT_IDX_DC_Q_HI     10'h0FB

// clock_detector_control fields
`define CDDT_BIT_DET_EN      0
`define CDDT_BIT_BALANCED    1
`define CDDT_BIT_RUNNING     2
`define CDDT_BIT_PD_LOSS     3
`define CDDT_BIT_PD_SE       4

// digital_test_control fields
`define CDDT_BIT_CLK_OFF     0
`define CDDT_BIT_TEST_EN     1
`define CDDT_RSV_LSB         2
`define CDDT_RSV_MSB         7

// reset values
`define CDDT_RST_DET_EN      1'h0
`define CDDT_RST_PD_LOSS     1'h0
`define CDDT_RST_PD_SE       1'h0
`define CDDT_RST_STATUS      1'h0
`define CDDT_RST_CLK_OFF     1'h0
`define CDDT_RST_TEST_EN     1'h0
`define CDDT_RST_DIG_RSV     6'h07
`define CDDT_RST_DC_BYTE     8'h00

`endif

// [src/cddt_sync2.v]
// two-flop synchroniser for level inputs from outside the pclk domain
`timescale 1ns/1ps
module cddt_sync2 (
  input  wire       pclk,     // register clock
  input  wire       presetn,  // async reset, active low
  input  wire [1:0] async_in, // raw levels
  output wire [1:0] sync_out  // synchronised levels
);

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[g];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[g] = sync_reg;
    end
  endgenerate

endmodule

// [src/cddt_test_source.v]
// selects normal channel data or the constant test value, registered
`timescale 1ns/1ps
module cddt_test_source (
  input  wire        pclk,      // register clock
  input  wire        presetn,   // async reset, active low
  input  wire        test_en,   // constant output test enable
  input  wire [15:0] i_const,   // i constant value
  input  wire [15:0] q_const,   // q constant value
  input  wire [15:0] i_in,      // normal i channel data
  input  wire [15:0] q_in,      // normal q channel data
  output reg  [15:0] i_out,     // i channel towards converter
  output reg  [15:0] q_out      // q channel towards converter
);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i_out <= 16'h0000;
      q_out <= 16'h0000;
    end else if (test_en) begin
      i_out <= i_const;
      q_out <= q_const;
    end else begin
      i_out <= i_in;
      q_out <= q_in;
    end
  end

endmodule

// [tb/cddt_checker.sv]
// assertions on the ports of the clock detector and dc test register bank
`timescale 1ns/1ps
module cddt_checker (
  input wire logic        pclk,                        // clock
  input wire logic        presetn,                     // reset
  input wire logic        psel,                        // select
  input wire logic        penable,                     // enable
  input wire logic        pwrite,                      // direction
  input wire logic [11:0] paddr,                       // address
  input wire logic [31:0] pwdata,                      // write data
  input wire logic [31:0] prdata,                      // read data
  input wire logic        pslverr,                     // error
  input wire logic [15:0] i_data_in,                   // i in
  input wire logic [15:0] i_data_out,                  // i out
  input wire logic [15:0] q_data_out,                  // q out
  input wire logic        converter_power_down,        // forced pd
  input wire logic        detector_enable,             // detector on
  input wire logic        top_logic_clock_off,         // clock off
  input wire logic        constant_output_test_enable, // test mode
  input wire logic [15:0] i_constant_value,            // i const
  input wire logic [15:0] q_constant_value             // q const
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
  err_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad read data");
  rd_upper_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  en_write_a: assert property (wr && paddr == 12'h238 |=> detector_enable == $past(pwdata[0])) else $error("enable");
  test_ctrl_a: assert property (wr && paddr == 12'h3DC |=> top_logic_clock_off == $past(pwdata[0])
    && constant_output_test_enable == $past(pwdata[1])) else $error("test control");
  i_const_a: assert property (presetn && $past(presetn) && $past(constant_output_test_enable)
    |-> i_data_out == $past(i_constant_value)) else $error("i constant");
  q_const_a: assert property (presetn && $past(presetn) && $past(constant_output_test_enable)
    |-> q_data_out == $past(q_constant_value)) else $error("q constant");
  pass_thru_a: assert property (presetn && $past(presetn) && !$past(constant_output_test_enable)
    |-> i_data_out == $past(i_data_in)) else $error("i pass");
  pd_gate_a: assert property (converter_power_down |-> $past(detector_enable) || $past(detector_enable, 2))
    else $error("pd while off");
endmodule
bind cddt_top cddt_checker u_chk (.*);

// [tb/clock_detect_dc_test_ctrl_bench.sv]
// self-checking bench for the clock detector and dc test register bank
`timescale 1ns/1ps
module clock_detect_dc_test_ctrl_bench;
  typedef struct packed {logic [11:0] a; logic [7:0] r, w, e; logic s;} cddt_row_t;
  logic        pclk, presetn, psel, penable, pwrite, run_raw, bal_raw, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [15:0] i_in, q_in;
  wire         pready, pslverr, pd, den, coff, ten;
  wire  [31:0] prdata;
  wire  [15:0] i_out, q_out, i_c, q_c;
  int          num_errors = 0, n_tests = 0, k;
  cddt_row_t   rows[8] = '{
    '{12'h238, 8'h00, 8'hFF, 8'h19, 1'h0}, '{12'h3E0, 8'h00, 8'hA5, 8'hA5, 1'h0},
    '{12'h3E4, 8'h00, 8'h5A, 8'h5A, 1'h0}, '{12'h3E8, 8'h00, 8'h3C, 8'h3C, 1'h0},
    '{12'h3EC, 8'h00, 8'hC3, 8'hC3, 1'h0}, '{12'h3DC, 8'h1C, 8'hFF, 8'hFF, 1'h0},
    '{12'h000, 8'h00, 8'hFF, 8'h00, 1'h1}, '{12'h239, 8'h00, 8'hFF, 8'h00, 1'h1}};

  cddt_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .sample_clock_running_raw(run_raw), .sample_clock_balanced_raw(bal_raw), .i_data_in(i_in),
    .q_data_in(q_in), .i_data_out(i_out), .q_data_out(q_out), .converter_power_down(pd),
    .detector_enable(den), .top_logic_clock_off(coff), .constant_output_test_enable(ten),
    .i_constant_value(i_c), .q_constant_value(q_c));

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  task end_sim;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, x);
    end
  endtask

  // one idle cycle after each transfer keeps psel from being driven twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      num_errors++;
      end_sim;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 32'h0);
    chk(rd, x);
  endtask

  initial begin
    {psel, penable, pwrite, run_raw, bal_raw} = 0;
    paddr = 0; pwdata = 0; i_in = 16'h1234; q_in = 16'hABCD; presetn = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    foreach (rows[j]) begin
      rdchk(rows[j].a, {24'h0, rows[j].r});
      apb(1, rows[j].a, {24'h0, rows[j].w});
      rdchk(rows[j].a, {24'h0, rows[j].e});
      chk({31'h0, er}, {31'h0, rows[j].s});
    end
    chk({31'h0, pd}, 32'h1);
    chk({i_c, q_c}, 32'h5AA5C33C);
    chk({i_out, q_out}, 32'h5AA5C33C);
    chk({29'h0, coff, ten, den}, 32'h7);
    run_raw <= 1; bal_raw <= 1;
    repeat (6) @(posedge pclk);
    rdchk(12'h238, 32'h1F);
    chk({31'h0, pd}, 32'h0);
    bal_raw <= 0;
    repeat (6) @(posedge pclk);
    rdchk(12'h238, 32'h1D);
    chk({31'h0, pd}, 32'h1);
    apb(1, 12'h238, 32'h09);
    repeat (2) @(posedge pclk);
    chk({31'h0, pd}, 32'h0);
    run_raw <= 0;
    repeat (6) @(posedge pclk);
    rdchk(12'h238, 32'h09);
    chk({31'h0, pd}, 32'h1);
    apb(1, 12'h238, 32'h01);
    repeat (2) @(posedge pclk);
    chk({31'h0, pd}, 32'h0);
    apb(1, 12'h238, 32'h18);
    run_raw <= 1; bal_raw <= 1;
    repeat (6) @(posedge pclk);
    rdchk(12'h238, 32'h18);
    chk({31'h0, pd}, 32'h0);
    apb(1, 12'h3DC, 32'h0);
    i_in <= 16'h0F0F;
    repeat (2) @(posedge pclk);
    chk({i_out, q_out}, 32'h0F0FABCD);
    chk({31'h0, coff}, 32'h0);
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdchk(12'h3E0, 32'h0);
    rdchk(12'h238, 32'h0);
    end_sim;
  end
endmodule
